// file: design/adccr_pkg.sv
// Package: register map, field layout and reset values of the channel bank
package adccr_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned REG_W  = 16;
   localparam int unsigned CAL_W  = 24;
   localparam int unsigned SAMP_W = 24;

   // Printed offsets are word indices; byte address is four times the index
   localparam logic [5:0] IDX_GLOBAL_DC   = 6'h08;
   localparam logic [5:0] IDX_CHANNEL0_CONFIG     = 6'h09;
   localparam logic [5:0] IDX_CH0_OFS_UP  = 6'h0a;
   localparam logic [5:0] IDX_CH0_OFS_LO  = 6'h0b;
   localparam logic [5:0] IDX_CH0_GAIN_UP = 6'h0c;
   localparam logic [5:0] IDX_CH0_GAIN_LO = 6'h0d;
   localparam logic [5:0] IDX_CHANNEL1_CONFIG     = 6'h0e;

   localparam logic [REG_W-1:0] RST_ZERO    = 16'h0000;
   localparam logic [REG_W-1:0] RST_GAIN_UP = 16'h8000;

   // Configuration layout
   localparam int unsigned PH_HI   = 15;
   localparam int unsigned PH_LO   = 6;
   localparam int unsigned DCB_BIT = 2;
   localparam int unsigned SEL_HI  = 1;
   localparam int unsigned SEL_LO  = 0;
   localparam logic [REG_W-1:0] CFG_MASK     = 16'hffc7;
   localparam logic [REG_W-1:0] CAL_LO_MASK  = 16'hff00;
   localparam logic [REG_W-1:0] GDC_MASK     = 16'h000f;
   localparam logic [DATA_W-1:0] UNMAPPED_RD = 32'h0000_0000;

   typedef enum logic [1:0] {
      ADCCR_SEL_EXT = 2'b00,
      ADCCR_SEL_SHORT = 2'b01,
      ADCCR_SEL_POS_TEST = 2'b10,
      ADCCR_SEL_NEG_TEST = 2'b11
   } adccr_sel_t;
endpackage

// file: design/adccr_cal.sv
// Offset then gain correction of one 24-bit sample
`timescale 1ns/100ps
`default_nettype none
module adccr_cal
   import adccr_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              reset,
   input  wire logic              in_valid,
   input  wire logic [SAMP_W-1:0] in_data,
   input  wire logic [CAL_W-1:0]  offset_val,
   input  wire logic [CAL_W-1:0]  gain_val,
   output logic                   out_valid,
   output logic [SAMP_W-1:0]      out_data
);
   localparam logic signed [SAMP_W-1:0] SAT_MAX = 24'h7f_ffff;
   localparam logic signed [SAMP_W-1:0] SAT_MIN = 24'h80_0000;

   function automatic logic [SAMP_W-1:0] sat24(input logic signed [48:0] v);
      if (v > 49'(SAT_MAX)) return SAT_MAX;
      else if (v < 49'(SAT_MIN)) return SAT_MIN;
      else return v[SAMP_W-1:0];
   endfunction

   // Gain is unsigned with one integer bit: product shifted right by 23
   logic signed [24:0] ofs_sum;
   logic signed [48:0] prod;
   logic [SAMP_W-1:0]  corr;
   assign ofs_sum = 25'($signed(in_data)) + 25'($signed(offset_val));
   // Widen both factors first so the product keeps all 49 bits
   assign prod = (49'(ofs_sum) * 49'($signed({1'b0, gain_val}))) >>> 23;
   assign corr = sat24(prod);

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         out_valid <= 1'b0;
         out_data  <= '0;
      end else begin
         out_valid <= in_valid;
         if (in_valid) out_data <= corr;
      end
   end
endmodule // adccr_cal
`default_nettype wire

// file: design/adccr_regs.sv
// Channel configuration and calibration register bank with Avalon-MM slave
`timescale 1ns/100ps
`default_nettype none
module adccr_regs
   import adccr_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              reset,
   input  wire logic [ADDR_W-1:0] avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [DATA_W-1:0] avs_writedata,
   input  wire logic [3:0]        avs_byteenable,
   output logic [DATA_W-1:0]      avs_readdata,
   output logic                   avs_waitrequest,
   output logic [1:0]             avs_response,
   output logic signed [9:0]      ch0_phase_delay,
   output logic signed [9:0]      ch1_phase_delay,
   output logic                   ch0_dc_filter_active,
   output logic                   ch1_dc_filter_active,
   output logic [3:0]             ch0_dc_filter_mode,
   output logic [3:0]             ch1_dc_filter_mode,
   output logic [1:0]             ch0_input_select,
   output logic [1:0]             ch1_input_select,
   output logic                   ch0_route_pos_input,
   output logic                   ch0_route_neg_input,
   output logic                   ch1_route_pos_input,
   output logic                   ch1_route_neg_input,
   output logic                   ch0_inputs_shorted,
   output logic                   ch1_inputs_shorted,
   output logic [1:0]             ch0_test_level,
   output logic [1:0]             ch1_test_level,
   input  wire logic              ch0_sample_valid,
   input  wire logic [SAMP_W-1:0] ch0_sample,
   output logic                   ch0_result_valid,
   output logic [SAMP_W-1:0]      ch0_result
);
   localparam logic [1:0] RESP_OK  = 2'b00;
   localparam logic [1:0] RESP_ERR = 2'b11;

   // Registers
   logic [REG_W-1:0] gdc_r;
   logic [REG_W-1:0] channel0_config_r;
   logic [REG_W-1:0] ofs_up_r;
   logic [REG_W-1:0] ofs_lo_r;
   logic [REG_W-1:0] gain_up_r;
   logic [REG_W-1:0] gain_lo_r;
   logic [REG_W-1:0] channel1_config_r;
   logic             ack_r;
   logic [DATA_W-1:0] rdata_r;
   logic [1:0]       resp_r;

   // Merge byte-enabled write data, then drop bits outside the writable mask
   function automatic logic [REG_W-1:0] merge(
      input logic [REG_W-1:0] old,
      input logic [REG_W-1:0] wd,
      input logic [1:0]       be,
      input logic [REG_W-1:0] mask);
      logic [REG_W-1:0] v;
      v = old;
      if (be[0]) v[7:0] = wd[7:0];
      if (be[1]) v[15:8] = wd[15:8];
      return v & mask;
   endfunction

   // Address decode; low two bits must be zero for aligned words
   wire [5:0] idx      = avs_address[ADDR_W-1:2];
   wire       aligned  = (avs_address[1:0] == 2'b00);
   wire       req      = avs_read | avs_write;
   wire       take     = req & ~ack_r;
   wire       wr_take  = take & avs_write & aligned;
   wire [1:0] be_lo    = avs_byteenable[1:0];
   wire [REG_W-1:0] wd = avs_writedata[REG_W-1:0];

   wire hit_gdc  = aligned & (idx == IDX_GLOBAL_DC);
   wire hit_c0   = aligned & (idx == IDX_CHANNEL0_CONFIG);
   wire hit_ou   = aligned & (idx == IDX_CH0_OFS_UP);
   wire hit_ol   = aligned & (idx == IDX_CH0_OFS_LO);
   wire hit_gu   = aligned & (idx == IDX_CH0_GAIN_UP);
   wire hit_gl   = aligned & (idx == IDX_CH0_GAIN_LO);
   wire hit_c1   = aligned & (idx == IDX_CHANNEL1_CONFIG);
   wire hit_any  = hit_gdc | hit_c0 | hit_ou | hit_ol | hit_gu | hit_gl
                   | hit_c1;

   wire [REG_W-1:0] rd_mux =
      hit_gdc ? gdc_r :
      hit_c0  ? channel0_config_r :
      hit_ou  ? ofs_up_r :
      hit_ol  ? ofs_lo_r :
      hit_gu  ? gain_up_r :
      hit_gl  ? gain_lo_r :
      hit_c1  ? channel1_config_r : RST_ZERO;

   // Next values; masks keep reserved bits at zero
   wire [REG_W-1:0] gdc_nxt = (wr_take & hit_gdc) ?
      merge(gdc_r, wd, be_lo, GDC_MASK) : gdc_r;
   wire [REG_W-1:0] channel0_config_nxt = (wr_take & hit_c0) ?
      merge(channel0_config_r, wd, be_lo, CFG_MASK) : channel0_config_r;
   wire [REG_W-1:0] ofs_up_nxt = (wr_take & hit_ou) ?
      merge(ofs_up_r, wd, be_lo, 16'hffff) : ofs_up_r;
   wire [REG_W-1:0] ofs_lo_nxt = (wr_take & hit_ol) ?
      merge(ofs_lo_r, wd, be_lo, CAL_LO_MASK) : ofs_lo_r;
   wire [REG_W-1:0] gain_up_nxt = (wr_take & hit_gu) ?
      merge(gain_up_r, wd, be_lo, 16'hffff) : gain_up_r;
   wire [REG_W-1:0] gain_lo_nxt = (wr_take & hit_gl) ?
      merge(gain_lo_r, wd, be_lo, CAL_LO_MASK) : gain_lo_r;
   wire [REG_W-1:0] channel1_config_nxt = (wr_take & hit_c1) ?
      merge(channel1_config_r, wd, be_lo, CFG_MASK) : channel1_config_r;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         gdc_r     <= RST_ZERO;
         channel0_config_r <= RST_ZERO;
         ofs_up_r  <= RST_ZERO;
         ofs_lo_r  <= RST_ZERO;
         gain_up_r <= RST_GAIN_UP;
         gain_lo_r <= RST_ZERO;
         channel1_config_r <= RST_ZERO;
      end else begin
         gdc_r     <= gdc_nxt;
         channel0_config_r <= channel0_config_nxt;
         ofs_up_r  <= ofs_up_nxt;
         ofs_lo_r  <= ofs_lo_nxt;
         gain_up_r <= gain_up_nxt;
         gain_lo_r <= gain_lo_nxt;
         channel1_config_r <= channel1_config_nxt;
      end
   end

   // One wait state: request taken on first edge, answered on the second
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ack_r   <= 1'b0;
         rdata_r <= UNMAPPED_RD;
         resp_r  <= RESP_OK;
      end else begin
         ack_r   <= take;
         if (take) begin
            rdata_r <= (avs_read & hit_any) ? {16'h0000, rd_mux}
                                            : UNMAPPED_RD;
            resp_r  <= hit_any ? RESP_OK : RESP_ERR;
         end
      end
   end

   assign avs_waitrequest = req & ~ack_r;
   assign avs_readdata    = rdata_r;
   assign avs_response    = resp_r;

   // Configuration fields out to the channels
   assign ch0_phase_delay = $signed(channel0_config_r[PH_HI:PH_LO]);
   assign ch1_phase_delay = $signed(channel1_config_r[PH_HI:PH_LO]);
   assign ch0_dc_filter_active = ~channel0_config_r[DCB_BIT];
   assign ch1_dc_filter_active = ~channel1_config_r[DCB_BIT];
   // Bypassed channel reports mode zero so the filter sees no setting
   assign ch0_dc_filter_mode = channel0_config_r[DCB_BIT] ? 4'h0 : gdc_r[3:0];
   assign ch1_dc_filter_mode = channel1_config_r[DCB_BIT] ? 4'h0 : gdc_r[3:0];
   assign ch0_input_select = channel0_config_r[SEL_HI:SEL_LO];
   assign ch1_input_select = channel1_config_r[SEL_HI:SEL_LO];

   wire ch0_ext = (ch0_input_select == ADCCR_SEL_EXT);
   wire ch1_ext = (ch1_input_select == ADCCR_SEL_EXT);
   assign ch0_route_pos_input = ch0_ext;
   assign ch0_route_neg_input = ch0_ext;
   assign ch1_route_pos_input = ch1_ext;
   assign ch1_route_neg_input = ch1_ext;
   assign ch0_inputs_shorted = (ch0_input_select == ADCCR_SEL_SHORT);
   assign ch1_inputs_shorted = (ch1_input_select == ADCCR_SEL_SHORT);
   // Bit 1 positive test, bit 0 negative test level
   assign ch0_test_level = {ch0_input_select == ADCCR_SEL_POS_TEST,
                            ch0_input_select == ADCCR_SEL_NEG_TEST};
   assign ch1_test_level = {ch1_input_select == ADCCR_SEL_POS_TEST,
                            ch1_input_select == ADCCR_SEL_NEG_TEST};

   // Full 24-bit values from both halves of each pair
   wire [CAL_W-1:0] ofs_full  = {ofs_up_r, ofs_lo_r[15:8]};
   wire [CAL_W-1:0] gain_full = {gain_up_r, gain_lo_r[15:8]};

   adccr_cal u_cal (
      .ref_clk    (ref_clk),
      .reset      (reset),
      .in_valid   (ch0_sample_valid),
      .in_data    (ch0_sample),
      .offset_val (ofs_full),
      .gain_val   (gain_full),
      .out_valid  (ch0_result_valid),
      .out_data   (ch0_result)
   );
endmodule // adccr_regs
`default_nettype wire

// file: tb/adccr_regs_checker.sv
// Concurrent checks on the register bank bus and field outputs
`timescale 1ns/100ps
`default_nettype none
module adccr_regs_checker (
   input wire logic              ref_clk,
   input wire logic              reset,
   input wire logic [7:0]        avs_address,
   input wire logic              avs_read,
   input wire logic              avs_write,
   input wire logic [31:0]       avs_writedata,
   input wire logic [31:0]       avs_readdata,
   input wire logic              avs_waitrequest,
   input wire logic [1:0]        avs_response,
   input wire logic signed [9:0] ch0_phase_delay,
   input wire logic              ch0_dc_filter_active,
   input wire logic [3:0]        ch0_dc_filter_mode,
   input wire logic [1:0]        ch0_input_select,
   input wire logic              ch0_route_pos_input,
   input wire logic              ch0_inputs_shorted,
   input wire logic [1:0]        ch0_test_level,
   input wire logic              ch0_sample_valid,
   input wire logic              ch0_result_valid
);
   wire logic wr_taken = avs_write && !avs_waitrequest;
   wire logic rd_taken = avs_read && !avs_waitrequest;
   wire logic [1:0] sel = ch0_input_select;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   a_wait_one_cycle: assert property ($rose(avs_read || avs_write) |->
      avs_waitrequest ##1 !avs_waitrequest) else $error("wait length");
   a_phase_write: assert property (wr_taken && avs_address == 8'h24 |=>
      ch0_phase_delay == $past(avs_writedata[15:6])) else $error("phase");
   a_bypass_write: assert property (wr_taken && avs_address == 8'h24 |=>
      ch0_dc_filter_active == !$past(avs_writedata[2])) else $error("bypass");
   a_bypass_mode: assert property (!ch0_dc_filter_active |->
      ch0_dc_filter_mode == 4'h0) else $error("bypass mode");
   a_select_decode: assert property (ch0_route_pos_input == (sel == 2'b00)
      && ch0_inputs_shorted == (sel == 2'b01)
      && ch0_test_level == {sel == 2'b10, sel == 2'b11}) else $error("select");
   a_cal_low_zero: assert property (rd_taken && avs_address inside {8'h2c,
      8'h34} |-> avs_readdata[7:0] == 8'h00) else $error("cal low byte");
   a_cfg_resv_zero: assert property (rd_taken && avs_address inside {8'h24,
      8'h38} |-> avs_readdata[5:3] == 3'b000) else $error("cfg reserved");
   a_unmapped_read: assert property (rd_taken && avs_address == 8'h3c |->
      avs_readdata == 32'h0000_0000 && avs_response == 2'b11)
      else $error("unmapped read");
   a_result_latency: assert property (ch0_sample_valid |=>
      ch0_result_valid) else $error("result latency");
endmodule // adccr_regs_checker
bind adccr_regs adccr_regs_checker adccr_regs_checker_i (.*);
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the channel configuration register bank
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic              ref_clk, reset, avs_read, avs_write;
   logic [7:0]        avs_address;
   logic [31:0]       avs_writedata, r;
   logic [3:0]        avs_byteenable;
   logic [1:0]        sel;
   logic              ch0_sample_valid;
   logic [23:0]       ch0_sample;
   wire logic [31:0]  avs_readdata;
   wire logic         avs_waitrequest, rv;
   wire logic [1:0]   avs_response, s0, s1, t0;
   wire logic signed [9:0] ph0;
   wire logic [3:0]   m0, m1;
   wire logic         pos0, sh0;
   wire logic [23:0]  res;
   int                mismatches, checks, cyc;
   localparam logic [7:0]  RA [7] = '{8'h20, 8'h24, 8'h28, 8'h2c, 8'h30,
                                      8'h34, 8'h38};
   adccr_regs adccr_regs_i (.ref_clk(ref_clk), .reset(reset),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .avs_response(avs_response), .ch0_phase_delay(ph0),
      .ch1_phase_delay(), .ch0_dc_filter_active(), .ch1_dc_filter_active(),
      .ch0_dc_filter_mode(m0), .ch1_dc_filter_mode(m1),
      .ch0_input_select(s0), .ch1_input_select(s1),
      .ch0_route_pos_input(pos0), .ch0_route_neg_input(),
      .ch1_route_pos_input(), .ch1_route_neg_input(),
      .ch0_inputs_shorted(sh0), .ch1_inputs_shorted(), .ch0_test_level(t0),
      .ch1_test_level(), .ch0_sample_valid(ch0_sample_valid),
      .ch0_sample(ch0_sample), .ch0_result_valid(rv), .ch0_result(res));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [15:0] d);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= {16'h0000, d};
      avs_write <= w;
      avs_read <= !w;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      r = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic samp(input logic [23:0] s, input logic [23:0] e);
      @(posedge ref_clk);
      ch0_sample_valid <= 1'b1;
      ch0_sample <= s;
      @(posedge ref_clk);
      ch0_sample_valid <= 1'b0;
      @(posedge ref_clk);
      chk({rv, res}, {1'b1, e});
   endtask
   task automatic t_reset;
      for (int i = 0; i < 7; i++) begin
         bus(1'b0, RA[i], 16'h0000);
         chk(r, (i == 4) ? 32'h0000_8000 : 32'h0000_0000);
      end
      foreach (RA[i]) bus(1'b0, 8'h3c, 16'h0000);
      chk({avs_response, r}, {2'b11, 32'h0000_0000});
      bus(1'b0, 8'h25, 16'h0000);
      chk(avs_response, 2'b11);
      samp(24'h00_0123, 24'h00_0123);
   endtask
   task automatic t_cfg;
      logic [15:0] d;
      bus(1'b1, 8'h20, 16'hfffa);
      for (int i = 0; i < 4; i++) begin
         sel = i[1:0];
         d = {10'h200 + {8'h00, sel}, 3'b111, sel[0], sel};
         bus(1'b1, 8'h24, d);
         bus(1'b1, 8'h38, ~d);
         bus(1'b0, 8'h24, 16'h0000);
         chk(r, {16'h0000, d & 16'hffc7});
         chk($unsigned(ph0), d[15:6]);
         chk({pos0, sh0, t0}, {sel == 2'b00, sel == 2'b01, sel == 2'b10,
             sel == 2'b11});
         chk(m0, sel[0] ? 4'h0 : 4'ha);
         bus(1'b0, 8'h38, 16'h0000);
         chk(r, {16'h0000, ~d & 16'hffc7});
         chk({s1, m1}, {~sel, sel[0] ? 4'ha : 4'h0});
      end
   endtask
   // Low bytes written as ones must not reach the calibration values
   task automatic t_cal;
      bus(1'b1, 8'h28, 16'h0001);
      bus(1'b1, 8'h2c, 16'h12ff);
      bus(1'b1, 8'h30, 16'h4000);
      bus(1'b1, 8'h34, 16'h00ff);
      bus(1'b0, 8'h2c, 16'h0000);
      chk(r, 32'h0000_1200);
      bus(1'b0, 8'h34, 16'h0000);
      chk(r, 32'h0000_0000);
      bus(1'b0, 8'h28, 16'h0000);
      chk(r, 32'h0000_0001);
      bus(1'b0, 8'h30, 16'h0000);
      chk(r, 32'h0000_4000);
      samp(24'h00_0200, 24'h00_0189);
      samp(24'hff_fe00, 24'hff_ff89);
   endtask
   task automatic end_sim;
      if (mismatches == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         mismatches++;
         end_sim();
      end
   end
   initial begin
      reset = 1'b1;
      {avs_read, avs_write, ch0_sample_valid} = 3'b000;
      {avs_address, avs_writedata, ch0_sample} = '0;
      avs_byteenable = 4'hf;
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      t_reset();
      t_cfg();
      t_cal();
      end_sim();
   end
endmodule // tb
`default_nettype wire
